/* hw/dsh_pkg.sv */
// constants and types for the offset servo and headphone stage register bank
package dsh_pkg;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_SERVO_ENABLE = 8'h43;
	localparam logic [7:0] ADDR_SERVO_MODE = 8'h45;
	localparam logic [7:0] ADDR_LL_PRESET = 8'h49;
	localparam logic [7:0] ADDR_RL_PRESET = 8'h4a;
	localparam logic [7:0] ADDR_LH_READBACK = 8'h51;
	localparam logic [7:0] ADDR_RH_READBACK = 8'h52;
	localparam logic [7:0] ADDR_LL_READBACK = 8'h53;
	localparam logic [7:0] ADDR_RL_READBACK = 8'h54;
	localparam logic [7:0] ADDR_HP_CTRL = 8'h5a;

	// ----------------------------------------
	// field positions and channel indices
	// ----------------------------------------
	localparam int NUM_CH = 4;
	localparam int CH_LH = 3;
	localparam int CH_RH = 2;
	localparam int CH_LL = 1;
	localparam int CH_RL = 0;
	localparam int HP_SHORT_BIT = 7;
	localparam int HP_OUTP_BIT = 6;
	localparam int HP_MID_BIT = 5;
	localparam int HP_IN_BIT = 4;
	localparam int HP_FIELD_LSB = 4;
	localparam int MODE_LSB = 0;
	localparam int ENABLE_LSB = 0;

	// ----------------------------------------
	// reset values and value range
	// ----------------------------------------
	localparam logic [7:0] RST_VALUE = 8'h00;
	localparam logic [3:0] RST_ENABLES = 4'h0;
	localparam logic [3:0] RST_HP_CTRL = 4'h0;
	localparam logic [7:0] VALUE_MAX = 8'h7f;
	localparam logic [7:0] VALUE_MIN = 8'h80;

	typedef enum logic [1:0] {
		MODE_WRITE_STOP = 2'b00,
		MODE_WRITE_UPDATE = 2'b01,
		MODE_START_STOP = 2'b10,
		MODE_START_UPDATE = 2'b11
	} dsh_mode_t;

endpackage : dsh_pkg

/* hw/dsh_chan_if.sv */
// link between the register bank and one offset servo channel
`timescale 1ns/10ps
`default_nettype none
interface dsh_chan_if;
	logic enable;
	dsh_pkg::dsh_mode_t mode;
	logic [7:0] preset;
	logic [7:0] step;
	logic step_valid;
	logic [7:0] integ;
	logic running;

	modport ctrl (output enable, output mode, output preset, output step, output step_valid,
		input integ, input running);
	modport chan (input enable, input mode, input preset, input step, input step_valid,
		output integ, output running);
endinterface : dsh_chan_if
`default_nettype wire

/* hw/dsh_servo_chan.sv */
// one offset servo channel: integrator value, write/start and stop/update sequencing
`timescale 1ns/10ps
`default_nettype none
module dsh_servo_chan (
	// clock, enable and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// register bank side
	dsh_chan_if.chan io
);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_ONCE = 2'b10
	} dsh_chan_state_t;

	typedef struct packed {
		dsh_chan_state_t st;
		logic en_q;
		logic [7:0] integ;
	} dsh_chan_reg_t;

	dsh_chan_reg_t r;
	dsh_chan_reg_t next_r;

	// saturate so a long run of steps never wraps past the +/-32 mV ends
	function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] sum;
		sum = {a[7], a} + {b[7], b};
		if (sum[8] != sum[7]) begin
			sat_add = sum[8] ? dsh_pkg::VALUE_MIN : dsh_pkg::VALUE_MAX;
		end else begin
			sat_add = sum[7:0];
		end
	endfunction : sat_add

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_r = r;
		next_r.en_q = io.enable;
		if (!io.enable) begin
			next_r.st = ST_IDLE;
		end else if (!r.en_q) begin
			unique case (io.mode)
				dsh_pkg::MODE_WRITE_STOP: begin
					next_r.integ = io.preset;
					next_r.st = ST_IDLE;
				end
				dsh_pkg::MODE_WRITE_UPDATE: begin
					next_r.integ = io.preset;
					next_r.st = ST_RUN;
				end
				dsh_pkg::MODE_START_STOP: begin
					next_r.integ = dsh_pkg::RST_VALUE;
					next_r.st = ST_ONCE;
				end
				dsh_pkg::MODE_START_UPDATE: begin
					next_r.integ = dsh_pkg::RST_VALUE;
					next_r.st = ST_RUN;
				end
			endcase
		end else begin
			unique case (r.st)
				ST_IDLE: begin
				end
				ST_RUN: begin
					if (io.step_valid) begin
						next_r.integ = sat_add(r.integ, io.step);
					end
				end
				ST_ONCE: begin
					if (io.step_valid) begin
						next_r.integ = sat_add(r.integ, io.step);
						next_r.st = ST_IDLE;
					end
				end
				default: begin
					next_r.st = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r <= '{st: ST_IDLE, en_q: 1'b0, integ: dsh_pkg::RST_VALUE};
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign io.integ = r.integ;
	assign io.running = (r.st != ST_IDLE);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	write_load_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && io.enable && !r.en_q && !io.mode[1] |=> r.integ == $past(io.preset))
		else $error("write mode did not load the preset");

	sat_top_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && io.enable && r.en_q && r.st == ST_RUN && io.step_valid && r.integ == 8'h7f
		&& !io.step[7] |=> r.integ == 8'h7f)
		else $error("integrator wrapped past its upper end");

	start_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && io.enable && !r.en_q && io.mode[1] |=> r.integ == 8'h00 && io.running)
		else $error("start mode did not clear and run");

	stop_once_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && io.enable && r.en_q && r.st == ST_ONCE && io.step_valid |=> !io.running)
		else $error("stop mode kept updating");

	run_cov: cover property (@(posedge clk) disable iff (!rst_n)
		r.st == ST_RUN && io.step_valid && ce);

endmodule : dsh_servo_chan
`default_nettype wire

/* hw/dsh_servo_hp_regs.sv */
// register bank for offset servo presets, readbacks and left headphone staging
`timescale 1ns/10ps
`default_nettype none
module dsh_servo_hp_regs (
	// clock, enable and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// headphone presets held by neighbouring registers
	input wire logic [7:0] left_phones_preset,
	input wire logic [7:0] right_phones_preset,
	// servo measurement steps, index per channel enable bit
	input wire logic [dsh_pkg::NUM_CH-1:0][7:0] servo_step,
	input wire logic [dsh_pkg::NUM_CH-1:0] servo_step_valid,
	// servo controls and applied offsets
	output logic [dsh_pkg::NUM_CH-1:0] offset_servo_channel_enables,
	output logic [1:0] offset_servo_operating_mode,
	output logic [dsh_pkg::NUM_CH-1:0][7:0] servo_offset_value,
	output logic [dsh_pkg::NUM_CH-1:0] servo_running,
	// left headphone stage controls
	output logic left_phones_short_release,
	output logic left_phones_output_stage_on,
	output logic left_phones_middle_stage_on,
	output logic left_phones_input_stage_on
);

	typedef struct packed {
		logic [7:0] left_line_offset_preset;
		logic [7:0] right_line_offset_preset;
		logic [3:0] ch_en;
		dsh_pkg::dsh_mode_t mode;
		logic [3:0] hp_ctrl;
		logic [7:0] rdata;
	} dsh_top_reg_t;

	dsh_top_reg_t r;
	dsh_top_reg_t next_r;

	logic [dsh_pkg::NUM_CH-1:0][7:0] preset_sel;
	logic [dsh_pkg::NUM_CH-1:0][7:0] integ_all;
	logic [dsh_pkg::NUM_CH-1:0] running_all;

	// ----------------------------------------
	// servo channels
	// ----------------------------------------
	dsh_chan_if ch_io[dsh_pkg::NUM_CH]();

	always_comb begin
		preset_sel = '0;
		preset_sel[dsh_pkg::CH_LH] = left_phones_preset;
		preset_sel[dsh_pkg::CH_RH] = right_phones_preset;
		preset_sel[dsh_pkg::CH_LL] = r.left_line_offset_preset;
		preset_sel[dsh_pkg::CH_RL] = r.right_line_offset_preset;
	end

	for (genvar i = 0; i < dsh_pkg::NUM_CH; i++) begin : g_ch
		assign ch_io[i].enable = r.ch_en[i];
		assign ch_io[i].mode = r.mode;
		assign ch_io[i].preset = preset_sel[i];
		assign ch_io[i].step = servo_step[i];
		assign ch_io[i].step_valid = servo_step_valid[i];
		assign integ_all[i] = ch_io[i].integ;
		assign running_all[i] = ch_io[i].running;

		dsh_servo_chan u_chan (
			.clk(clk),
			.rst_n(rst_n),
			.ce(ce),
			.io(ch_io[i])
		);
	end

	// ----------------------------------------
	// register access
	// ----------------------------------------
	always_comb begin
		next_r = r;
		// read data stands for one cycle only, zero otherwise
		next_r.rdata = dsh_pkg::RST_VALUE;
		if (reg_wr) begin
			case (reg_addr)
				dsh_pkg::ADDR_LL_PRESET: begin
					next_r.left_line_offset_preset = reg_wdata;
				end
				dsh_pkg::ADDR_RL_PRESET: begin
					next_r.right_line_offset_preset = reg_wdata;
				end
				dsh_pkg::ADDR_SERVO_ENABLE: begin
					next_r.ch_en = reg_wdata[dsh_pkg::ENABLE_LSB +: 4];
				end
				dsh_pkg::ADDR_SERVO_MODE: begin
					next_r.mode = dsh_pkg::dsh_mode_t'(reg_wdata[dsh_pkg::MODE_LSB +: 2]);
				end
				dsh_pkg::ADDR_HP_CTRL: begin
					next_r.hp_ctrl = reg_wdata[dsh_pkg::HP_FIELD_LSB +: 4];
				end
				default: begin
					// readback offsets land here and change nothing
					next_r.hp_ctrl = r.hp_ctrl;
				end
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				dsh_pkg::ADDR_LL_PRESET: next_r.rdata = r.left_line_offset_preset;
				dsh_pkg::ADDR_RL_PRESET: next_r.rdata = r.right_line_offset_preset;
				dsh_pkg::ADDR_SERVO_ENABLE: next_r.rdata = {4'h0, r.ch_en};
				dsh_pkg::ADDR_SERVO_MODE: next_r.rdata = {6'h00, r.mode};
				dsh_pkg::ADDR_HP_CTRL: next_r.rdata = {r.hp_ctrl, 4'h0};
				dsh_pkg::ADDR_LH_READBACK: next_r.rdata = integ_all[dsh_pkg::CH_LH];
				dsh_pkg::ADDR_RH_READBACK: next_r.rdata = integ_all[dsh_pkg::CH_RH];
				dsh_pkg::ADDR_LL_READBACK: next_r.rdata = integ_all[dsh_pkg::CH_LL];
				dsh_pkg::ADDR_RL_READBACK: next_r.rdata = integ_all[dsh_pkg::CH_RL];
				default: next_r.rdata = dsh_pkg::RST_VALUE;
			endcase
		end
	end

	// reset wins over the clock enable so a frozen block still comes up clean
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r <= '{left_line_offset_preset: dsh_pkg::RST_VALUE,
				right_line_offset_preset: dsh_pkg::RST_VALUE,
				ch_en: dsh_pkg::RST_ENABLES,
				mode: dsh_pkg::MODE_WRITE_STOP,
				hp_ctrl: dsh_pkg::RST_HP_CTRL,
				rdata: dsh_pkg::RST_VALUE};
		end else if (ce) begin
			r <= next_r;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign reg_rdata = r.rdata;
	assign offset_servo_channel_enables = r.ch_en;
	assign offset_servo_operating_mode = r.mode;
	assign servo_offset_value = integ_all;
	assign servo_running = running_all;
	// no interlock on stage order: sequencing is left to software
	assign left_phones_short_release = r.hp_ctrl[dsh_pkg::HP_SHORT_BIT - dsh_pkg::HP_FIELD_LSB];
	assign left_phones_output_stage_on = r.hp_ctrl[dsh_pkg::HP_OUTP_BIT - dsh_pkg::HP_FIELD_LSB];
	assign left_phones_middle_stage_on = r.hp_ctrl[dsh_pkg::HP_MID_BIT - dsh_pkg::HP_FIELD_LSB];
	assign left_phones_input_stage_on = r.hp_ctrl[dsh_pkg::HP_IN_BIT - dsh_pkg::HP_FIELD_LSB];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	preset_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && reg_wr && reg_addr == 8'h49 |=> preset_sel[dsh_pkg::CH_LL] == $past(reg_wdata))
		else $error("left line preset not stored");

	preset_apply_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && r.ch_en[0] == 1'b0 && next_r.ch_en[0] && r.mode == dsh_pkg::MODE_WRITE_STOP
		&& !(reg_wr && reg_addr == 8'h4a) |=> ##1 integ_all[0] == $past(r.right_line_offset_preset))
		else $error("right line preset not applied in write mode");

	readback_lh_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && reg_rd && reg_addr == 8'h51 |=> reg_rdata == $past(integ_all[3]))
		else $error("left phones readback wrong");

	readback_rl_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && reg_rd && reg_addr == 8'h54 |=> reg_rdata == $past(integ_all[0]))
		else $error("right line readback wrong");

	reset_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
		$past(!rst_n) |-> reg_rdata == 8'h00 && integ_all == '0
		&& r.left_line_offset_preset == 8'h00 && r.right_line_offset_preset == 8'h00)
		else $error("value not zero after reset");

	short_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && reg_wr && reg_addr == 8'h5a |=> left_phones_short_release == $past(reg_wdata[7])
		&& left_phones_output_stage_on == $past(reg_wdata[6]))
		else $error("short release or output stage bit misplaced");

	stage_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && reg_wr && reg_addr == 8'h5a |=> left_phones_middle_stage_on == $past(reg_wdata[5])
		&& left_phones_input_stage_on == $past(reg_wdata[4]))
		else $error("middle or input stage bit misplaced");

	stage_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!(ce && reg_wr && reg_addr == 8'h5a) |=> $stable(left_phones_input_stage_on)
		&& $stable(left_phones_short_release))
		else $error("stage bit changed without a write");

	mode_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && reg_wr && reg_addr == 8'h45 |=> offset_servo_operating_mode == $past(reg_wdata[1:0]))
		else $error("servo mode not stored");

	enable_map_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && reg_wr && reg_addr == 8'h43 |=> offset_servo_channel_enables == $past(reg_wdata[3:0]))
		else $error("servo enables not stored");

	readback_ro_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && reg_wr && reg_addr == 8'h53 && !servo_step_valid[1] && !r.ch_en[1]
		&& !ch_io[1].running |=> integ_all[1] == $past(integ_all[1]))
		else $error("write reached a readback register");

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	hp_full_cov: cover property (@(posedge clk) disable iff (!rst_n)
		left_phones_short_release && left_phones_output_stage_on
		&& left_phones_middle_stage_on && left_phones_input_stage_on);

	write_update_cov: cover property (@(posedge clk) disable iff (!rst_n)
		r.mode == dsh_pkg::MODE_WRITE_UPDATE && running_all[1]);

	readback_cov: cover property (@(posedge clk) disable iff (!rst_n)
		ce && reg_rd && reg_addr == 8'h53 ##1 reg_rdata != 8'h00);

endmodule : dsh_servo_hp_regs
`default_nettype wire

/* tb/dsh_servo_hp_regs_bench.sv */
// self-checking bench for the offset servo and headphone stage register bank
`timescale 1ns/10ps
`default_nettype none
module dsh_servo_hp_regs_bench;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic rst_n;
	logic ce;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic [7:0] lh_preset;
	logic [7:0] rh_preset;
	logic [3:0][7:0] servo_step;
	logic [3:0] servo_step_valid;
	logic [3:0] chan_en;
	logic [1:0] servo_mode;
	logic [3:0][7:0] offset_value;
	logic [3:0] running;
	logic [3:0] hp_stage;
	logic [3:0][7:0] lanes;
	logic [7:0] map_addr [9] = '{8'h43, 8'h45, 8'h49, 8'h4a, 8'h51, 8'h52, 8'h53, 8'h54, 8'h5a};
	logic [7:0] exp_first [4] = '{8'h12, 8'h12, 8'h00, 8'h00};
	logic [7:0] exp_one [4] = '{8'h12, 8'h13, 8'h01, 8'h01};
	logic [7:0] exp_two [4] = '{8'h12, 8'h14, 8'h01, 8'h02};
	int fail_count;
	int compares;

	dsh_servo_hp_regs dut (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.left_phones_preset(lh_preset),
		.right_phones_preset(rh_preset),
		.servo_step(servo_step),
		.servo_step_valid(servo_step_valid),
		.offset_servo_channel_enables(chan_en),
		.offset_servo_operating_mode(servo_mode),
		.servo_offset_value(offset_value),
		.servo_running(running),
		.left_phones_short_release(hp_stage[3]),
		.left_phones_output_stage_on(hp_stage[2]),
		.left_phones_middle_stage_on(hp_stage[1]),
		.left_phones_input_stage_on(hp_stage[0])
	);

	always #2.5 clk = ~clk;

	// ----------------------------------------
	// access tasks, entered at a rising edge except check, which is called 1 ns after one
	// ----------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// a spare cycle after each strobe so two writes never touch reg_wr in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check($sformatf("reg %h", a), reg_rdata, exp);
		@(posedge clk);
		#1;
		check("rdata idle", reg_rdata, 8'h00);
		@(posedge clk);
	endtask : rd_check

	task automatic step(input logic [3:0] m, input logic [3:0][7:0] v);
		servo_step <= v;
		servo_step_valid <= m;
		@(posedge clk);
		servo_step_valid <= 4'h0;
		repeat (2) @(posedge clk);
	endtask : step

	task automatic chk_ch(input int ch, input logic [7:0] e);
		#1;
		check($sformatf("offset ch%0d", ch), offset_value[ch], e);
		@(posedge clk);
		rd_check(8'h54 - 8'(ch), e);
	endtask : chk_ch

	task automatic tally_and_finish;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish

	// whole run is about 4300 cycles, the 20 us wait included
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		tally_and_finish();
	end

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		lh_preset = 8'h9c;
		rh_preset = 8'h63;
		servo_step = '0;
		servo_step_valid = 4'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 9; i++)
			rd_check(map_addr[i], 8'h00);
		check("outputs", {chan_en, hp_stage}, 8'h00);
		rd_check(8'h60, 8'h00);
		$display("test reset_values done");

		wr(8'h49, 8'h80);
		wr(8'h4a, 8'h7f);
		rd_check(8'h49, 8'h80);
		rd_check(8'h4a, 8'h7f);
		wr(8'h43, 8'hff);
		rd_check(8'h43, 8'h0f);
		#1;
		check("enable pins", {4'h0, chan_en}, 8'h0f);
		@(posedge clk);
		wr(8'h43, 8'h00);
		wr(8'h45, 8'hff);
		rd_check(8'h45, 8'h03);
		#1;
		check("mode pins", {6'h00, servo_mode}, 8'h03);
		@(posedge clk);
		wr(8'h45, 8'h00);
		ce <= 1'b0;
		wr(8'h49, 8'h55);
		ce <= 1'b1;
		rd_check(8'h49, 8'h80);
		for (int a = 8'h51; a <= 8'h54; a++)
			wr(8'(a), 8'h55);
		rd_check(8'h51, 8'h9c);
		rd_check(8'h52, 8'h63);
		rd_check(8'h53, 8'h80);
		rd_check(8'h54, 8'h7f);
		$display("test presets_and_readback done");

		// mode changes only act on a fresh enable edge, hence the clear each pass
		for (int m = 0; m < 4; m++) begin
			lanes = '0;
			lanes[1] = 8'h01;
			wr(8'h49, 8'h12);
			wr(8'h45, 8'(m));
			wr(8'h43, 8'h02);
			repeat (2) @(posedge clk);
			chk_ch(1, exp_first[m]);
			check("running", {7'h00, running[1]}, 8'(m != 0));
			step(4'h2, lanes);
			chk_ch(1, exp_one[m]);
			step(4'h2, lanes);
			chk_ch(1, exp_two[m]);
			wr(8'h43, 8'h00);
		end
		$display("test servo_modes done");

		lanes = '0;
		lanes[1] = 8'h03;
		lanes[0] = 8'hfe;
		wr(8'h49, 8'h7e);
		wr(8'h4a, 8'h81);
		wr(8'h45, 8'h01);
		wr(8'h43, 8'h03);
		repeat (2) @(posedge clk);
		step(4'h3, lanes);
		chk_ch(1, 8'h7f);
		chk_ch(0, 8'h80);
		step(4'h3, lanes);
		chk_ch(1, 8'h7f);
		chk_ch(0, 8'h80);
		wr(8'h43, 8'h00);
		step(4'h3, lanes);
		chk_ch(1, 8'h7f);
		$display("test saturation done");

		for (int i = 4; i < 8; i++) begin
			wr(8'h5a, 8'(1 << i));
			#1;
			check("stage bits", {4'h0, hp_stage}, 8'(1 << (i - 4)));
			@(posedge clk);
			rd_check(8'h5a, 8'(1 << i));
		end
		wr(8'h5a, 8'h0f);
		rd_check(8'h5a, 8'h00);
		wr(8'h5a, 8'h10);
		repeat (4000) @(posedge clk);
		wr(8'h5a, 8'h30);
		wr(8'h43, 8'h08);
		wr(8'h5a, 8'h70);
		wr(8'h5a, 8'hf0);
		#1;
		check("stage all on", {4'h0, hp_stage}, 8'h0f);
		$display("test phones_staging done");
		@(posedge clk);
		rd_check(8'h51, 8'h9c);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd_check(8'h51, 8'h00);
		rd_check(8'h53, 8'h00);
		rd_check(8'h49, 8'h00);
		#1;
		check("outputs after reset", {chan_en, hp_stage}, 8'h00);
		$display("test mid_reset done");
		tally_and_finish();
	end
endmodule : dsh_servo_hp_regs_bench
`default_nettype wire
